// File: shared/qssc_consts.svh
// constants for the status and serial configuration block
`ifndef QSSC_CONSTS_SVH
`define QSSC_CONSTS_SVH
// register byte offsets
`define QSSC_A_QCOND 8'h00
`define QSSC_A_QEVT 8'h04
`define QSSC_A_QEN 8'h08
`define QSSC_A_STB 8'h0C
`define QSSC_A_ADDR 8'h10
`define QSSC_A_BAUD 8'h14
`define QSSC_A_CTRL 8'h18
`define QSSC_A_BEEP 8'h1C
// questionable field layout
`define QSSC_QUSED 16'h704B
`define QSSC_QLATCH 16'h3000
`define QSSC_B_QSUM 3
// control register bits
`define QSSC_B_ECHO 0
`define QSSC_B_PACE 1
`define QSSC_B_PROMPT 2
// bus address limits and reset value
`define QSSC_ADDR_MAX 5'h1E
`define QSSC_ADDR_RST 5'h00
// baud rates and codes
`define QSSC_BAUD_19200 32'h0000_4B00
`define QSSC_BAUD_9600 32'h0000_2580
`define QSSC_BAUD_4800 32'h0000_12C0
`define QSSC_BAUD_2400 32'h0000_0960
`define QSSC_BSEL_19200 2'h0
`define QSSC_BSEL_9600 2'h1
`define QSSC_BSEL_4800 2'h2
`define QSSC_BSEL_2400 2'h3
// characters
`define QSSC_CH_LF 8'h0A
`define QSSC_CH_XON 8'h11
`define QSSC_CH_XOFF 8'h13
`define QSSC_CH_PROMPT 8'h3E
// beep timing
`define QSSC_BEEP_MS 100
`define QSSC_CLK_HZ 50000000
`endif

// File: shared/qssc_pkg.sv
// types shared by the status and serial configuration block
package qssc_pkg;
   // one serial character with its strobe
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } qssc_byte_s;
   // transmit slot state
   typedef enum logic {
      QSSC_TX_IDLE = 1'b0,
      QSSC_TX_BUSY = 1'b1
   } qssc_tx_e;
   // questionable register word
   typedef logic [15:0] qssc_word_t;
endpackage

// File: hdl/qssc_top.sv
// status group, serial settings, beep and apb register slave
// Summary of operation
// - condition register reads live, unlatched
// - condition bit one while condition active
// - both lowest condition bits may be set
// - enable mask gates events to summary
// - summary is OR of event AND enable
// - enable query returns stored mask unchanged
// - beep drives indicator one fixed interval
// - bus address 0 to 30, host follows
// - address query returns current address
// - only four baud rates, then used
// - baud query returns rate in use
// - echo on returns later characters, only newest kept while one waits
// - echo off takes effect after terminator
// - general reset leaves echo unchanged
// - echo query returns one or zero
// - xon enables flow control, none disables
// - flow query returns one or zero
// - prompt sends greater-than after each command
// - event read returns and clears bits
// - only bits 13 and 12 latch
`timescale 1ns/1ps
`include "qssc_consts.svh"
`default_nettype none

module qssc_top #(
   // beep length in clock cycles
   parameter int unsigned BEEP_CYCLES = `QSSC_BEEP_MS * (`QSSC_CLK_HZ / 1000)
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire qssc_pkg::qssc_word_t qcond,
   input wire qssc_pkg::qssc_byte_s rx,
   input wire logic cmd_parsed,
   input wire logic soft_rst,
   input wire logic tx_ready,
   output qssc_pkg::qssc_byte_s tx,
   output logic beep,
   output logic [4:0] gpib_addr,
   output logic [1:0] baud_sel,
   output logic xoff_hold,
   output logic qsum
);

   // bus handshake registers
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   // questionable event and enable
   qssc_pkg::qssc_word_t qevt_reg;
   qssc_pkg::qssc_word_t qen_reg;
   logic qsum_reg;
   // communication settings
   logic [4:0] addr_reg;
   logic [1:0] baud_reg;
   logic echo_on_reg;
   logic echo_act_reg;
   logic pace_reg;
   logic prompt_reg;
   logic xoff_reg;
   // beep timer
   logic [31:0] beep_cnt_reg;
   logic beep_reg;
   // transmit slot
   qssc_pkg::qssc_tx_e tx_st_reg;
   qssc_pkg::qssc_byte_s tx_reg;
   logic pend_echo_reg;
   logic [7:0] echo_byte_reg;
   logic pend_prompt_reg;

   // bus phase decode
   logic setup_w;
   logic done_w;
   logic wr_w;
   logic rd_w;
   logic [31:0] rd_val;
   logic rd_err;
   qssc_pkg::qssc_word_t evt_set;
   qssc_pkg::qssc_word_t evt_clr;
   logic [31:0] baud_val;
   logic baud_ok;
   logic [1:0] baud_code;
   logic tx_load_echo;
   logic tx_load_prompt;

   assign setup_w = psel & ~penable;
   assign done_w = psel & penable & pready_reg;
   assign wr_w = done_w & pwrite;
   assign rd_w = done_w & ~pwrite;

   // rate in use as a number
   always_comb begin
      case (baud_reg)
         `QSSC_BSEL_9600: baud_val = `QSSC_BAUD_9600;
         `QSSC_BSEL_4800: baud_val = `QSSC_BAUD_4800;
         `QSSC_BSEL_2400: baud_val = `QSSC_BAUD_2400;
         default: baud_val = `QSSC_BAUD_19200;
      endcase
   end

   // write data to baud code, only four rates valid
   always_comb begin
      baud_ok = 1'b1;
      baud_code = `QSSC_BSEL_19200;
      if (pwdata == `QSSC_BAUD_19200) begin
         baud_code = `QSSC_BSEL_19200;
      end else if (pwdata == `QSSC_BAUD_9600) begin
         baud_code = `QSSC_BSEL_9600;
      end else if (pwdata == `QSSC_BAUD_4800) begin
         baud_code = `QSSC_BSEL_4800;
      end else if (pwdata == `QSSC_BAUD_2400) begin
         baud_code = `QSSC_BSEL_2400;
      end else begin
         baud_ok = 1'b0;
      end
   end

   // read mux, evaluated in the setup cycle
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_err = 1'b0;
      if (paddr == `QSSC_A_QCOND) begin
         rd_val[15:0] = qcond & `QSSC_QUSED;
      end else if (paddr == `QSSC_A_QEVT) begin
         rd_val[15:0] = qevt_reg;
      end else if (paddr == `QSSC_A_QEN) begin
         rd_val[15:0] = qen_reg;
      end else if (paddr == `QSSC_A_STB) begin
         rd_val[`QSSC_B_QSUM] = qsum_reg;
      end else if (paddr == `QSSC_A_ADDR) begin
         rd_val[4:0] = addr_reg;
      end else if (paddr == `QSSC_A_BAUD) begin
         rd_val = baud_val;
      end else if (paddr == `QSSC_A_CTRL) begin
         rd_val[`QSSC_B_ECHO] = echo_on_reg;
         rd_val[`QSSC_B_PACE] = pace_reg;
         rd_val[`QSSC_B_PROMPT] = prompt_reg;
      end else if (paddr == `QSSC_A_BEEP) begin
         rd_val = 32'h0000_0000;
      end else begin
         rd_err = 1'b1; // unmapped
      end
   end

   // apb answer: no wait states, data captured at setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else if (setup_w) begin
         prdata_reg <= pwrite ? 32'h0000_0000 : rd_val;
         pready_reg <= 1'b1;
         pslverr_reg <= rd_err;
      end else begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
   end

   // event latch sources and read clear
   assign evt_set = qcond & `QSSC_QLATCH;
   assign evt_clr = (rd_w && paddr == `QSSC_A_QEVT) ? prdata_reg[15:0] : 16'h0000;

   // event register, set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qevt_reg <= 16'h0000;
      end else begin
         qevt_reg <= (qevt_reg & ~evt_clr) | evt_set;
      end
   end

   // enable mask, unused bits kept zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qen_reg <= 16'h0000;
      end else if (wr_w && paddr == `QSSC_A_QEN) begin
         qen_reg <= pwdata[15:0] & `QSSC_QUSED;
      end
   end

   // summary bit for the status byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         qsum_reg <= 1'b0;
      end else begin
         qsum_reg <= |(qevt_reg & qen_reg);
      end
   end

   // bus address, values above 30 ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_reg <= `QSSC_ADDR_RST;
      end else if (wr_w && paddr == `QSSC_A_ADDR) begin
         if (pwdata[31:5] == 27'h0 && pwdata[4:0] <= `QSSC_ADDR_MAX) begin
            addr_reg <= pwdata[4:0];
         end
      end
   end

   // baud selection, unsupported rates ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         baud_reg <= `QSSC_BSEL_19200;
      end else if (wr_w && paddr == `QSSC_A_BAUD && baud_ok) begin
         baud_reg <= baud_code;
      end
   end

   // control settings; general reset does not touch them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         echo_on_reg <= 1'b0;
         pace_reg <= 1'b0;
         prompt_reg <= 1'b0;
      end else if (wr_w && paddr == `QSSC_A_CTRL) begin
         echo_on_reg <= pwdata[`QSSC_B_ECHO];
         pace_reg <= pwdata[`QSSC_B_PACE];
         prompt_reg <= pwdata[`QSSC_B_PROMPT];
      end
   end

   // echo active: on at once, off after next terminator
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         echo_act_reg <= 1'b0;
      end else if (wr_w && paddr == `QSSC_A_CTRL && pwdata[`QSSC_B_ECHO]) begin
         echo_act_reg <= 1'b1;
      end else if (!echo_on_reg && rx.valid && rx.data == `QSSC_CH_LF) begin
         echo_act_reg <= 1'b0;
      end
   end

   // flow control hold from received xoff and xon
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xoff_reg <= 1'b0;
      end else if (!pace_reg || soft_rst) begin
         xoff_reg <= 1'b0;
      end else if (rx.valid && rx.data == `QSSC_CH_XOFF) begin
         xoff_reg <= 1'b1;
      end else if (rx.valid && rx.data == `QSSC_CH_XON) begin
         xoff_reg <= 1'b0;
      end
   end

   // beep timer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         beep_cnt_reg <= 32'h0000_0000;
         beep_reg <= 1'b0;
      end else if (wr_w && paddr == `QSSC_A_BEEP) begin
         beep_cnt_reg <= 32'(BEEP_CYCLES);
         beep_reg <= 1'b1;
      end else if (beep_cnt_reg != 32'h0000_0000) begin
         beep_cnt_reg <= beep_cnt_reg - 32'h0000_0001;
         beep_reg <= (beep_cnt_reg > 32'h0000_0001);
      end else begin
         beep_reg <= 1'b0;
      end
   end

   // slot loads when idle and not held off
   assign tx_load_echo = (tx_st_reg == qssc_pkg::QSSC_TX_IDLE) && pend_echo_reg && !xoff_reg;
   assign tx_load_prompt = (tx_st_reg == qssc_pkg::QSSC_TX_IDLE) && !pend_echo_reg
      && pend_prompt_reg && !xoff_reg;

   // pending echo byte, newest character kept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_echo_reg <= 1'b0;
         echo_byte_reg <= 8'h00;
      end else if (rx.valid && echo_act_reg) begin
         pend_echo_reg <= 1'b1;
         echo_byte_reg <= rx.data;
      end else if (tx_load_echo || soft_rst) begin
         pend_echo_reg <= 1'b0;
      end
   end

   // pending prompt after each parsed command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_prompt_reg <= 1'b0;
      end else if (cmd_parsed && prompt_reg) begin
         pend_prompt_reg <= 1'b1;
      end else if (tx_load_prompt || soft_rst) begin
         pend_prompt_reg <= 1'b0;
      end
   end

   // transmit slot state machine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st_reg <= qssc_pkg::QSSC_TX_IDLE;
         tx_reg <= '0;
      end else begin
         case (tx_st_reg)
            qssc_pkg::QSSC_TX_IDLE: begin
               if (tx_load_echo) begin
                  tx_reg.valid <= 1'b1;
                  tx_reg.data <= echo_byte_reg;
                  tx_st_reg <= qssc_pkg::QSSC_TX_BUSY;
               end else if (tx_load_prompt) begin
                  tx_reg.valid <= 1'b1;
                  tx_reg.data <= `QSSC_CH_PROMPT;
                  tx_st_reg <= qssc_pkg::QSSC_TX_BUSY;
               end
            end
            qssc_pkg::QSSC_TX_BUSY: begin
               // held until the serializer takes it
               if (tx_ready) begin
                  tx_reg.valid <= 1'b0;
                  tx_st_reg <= qssc_pkg::QSSC_TX_IDLE;
               end
            end
            default: begin
               tx_reg.valid <= 1'b0;
               tx_st_reg <= qssc_pkg::QSSC_TX_IDLE;
            end
         endcase
      end
   end

   // outputs straight from flops
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign tx = tx_reg;
   assign beep = beep_reg;
   assign gpib_addr = addr_reg;
   assign baud_sel = baud_reg;
   assign xoff_hold = xoff_reg;
   assign qsum = qsum_reg;

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_evt_read;
      rd_w && paddr == `QSSC_A_QEVT;
   endsequence

   a_summary_from_mask: assert property (
      (|(qevt_reg & qen_reg)) |=> qsum_reg)
      else $error("summary bit does not follow masked events");
   a_summary_clear: assert property (
      !(|(qevt_reg & qen_reg)) |=> !qsum_reg)
      else $error("summary bit set with no enabled event");
   a_event_latch_held: assert property (
      qcond[13] |=> qevt_reg[13])
      else $error("current error not latched");
   a_event_low_bits: assert property (
      (qevt_reg & ~`QSSC_QLATCH) == 16'h0000)
      else $error("unlatched bit in event register");
   a_event_read_clear: assert property (
      s_evt_read ##0 !qcond[12] && prdata_reg[12] |=> !qevt_reg[12])
      else $error("event bit not cleared by read");
   a_addr_in_range: assert property (
      addr_reg <= `QSSC_ADDR_MAX)
      else $error("bus address above 30");
   a_beep_fixed_len: assert property (
      $rose(beep_reg) |-> beep_cnt_reg == 32'(BEEP_CYCLES))
      else $error("beep started with wrong length");
   a_xoff_no_load: assert property (
      xoff_reg && tx_st_reg == qssc_pkg::QSSC_TX_IDLE |=> !tx_reg.valid)
      else $error("byte sent while held off");
   a_prompt_sent: assert property (
      tx_load_prompt |=> tx_reg.valid && tx_reg.data == `QSSC_CH_PROMPT)
      else $error("prompt character not sent");
   a_echo_held_until_lf: assert property (
      echo_act_reg && !echo_on_reg && rx.valid && rx.data != `QSSC_CH_LF
      && !wr_w |=> echo_act_reg)
      else $error("echo stopped before terminator");
   a_tx_stands: assert property (
      tx_reg.valid && !tx_ready |=> tx_reg.valid && $stable(tx_reg.data))
      else $error("tx byte dropped before taken");

endmodule // qssc_top

`default_nettype wire

// File: dv/qssc_host_model.sv
// remote host model: sends characters and takes echoed bytes with stalls
`timescale 1ns/1ps
`default_nettype none
module qssc_host_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire qssc_pkg::qssc_byte_s tx,
   output qssc_pkg::qssc_byte_s rx,
   output logic tx_ready
);
   logic [7:0] got_q[$]; // bytes taken from the transmitter
   logic [31:0] st = 32'h9E37_79B9; // stall pattern state
   initial rx = '0;
   initial tx_ready = 1'b0;
   // takes a byte at each edge with valid and ready, stalls at random
   always @(posedge pclk) begin
      if (presetn && tx.valid && tx_ready) begin
         got_q.push_back(tx.data);
      end
      st <= {st[30:0], st[31] ^ st[21] ^ st[1] ^ st[0]};
      tx_ready <= st[0] | st[3];
   end
   // one character with a one-cycle strobe, then the line shows the inverse
   task send(input logic [7:0] c);
      rx <= '{valid: 1'b1, data: c};
      @(posedge pclk);
      rx <= '{valid: 1'b0, data: ~c};
      @(posedge pclk);
   endtask
endmodule // qssc_host_model
`default_nettype wire

// File: dv/qssc_top_tb_top.sv
// self-checking bench for the status and serial configuration block
`timescale 1ns/1ps
`include "qssc_consts.svh"
`default_nettype none
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
   $display("Error %0t %s", $time, m); end end
module qssc_top_tb_top;
   localparam int unsigned BC = 20; // short beep for simulation
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   qssc_pkg::qssc_word_t qcond = 16'h0;
   qssc_pkg::qssc_byte_s rx;
   qssc_pkg::qssc_byte_s tx;
   logic cmd_parsed = 1'b0;
   logic soft_rst = 1'b0;
   logic tx_ready;
   logic beep;
   logic [4:0] gpib_addr;
   logic [1:0] baud_sel;
   logic xoff_hold;
   logic qsum;
   int bad_count = 0;
   int comparisons = 0;
   int beep_n = 0; // cycles seen with the indicator on
   logic [31:0] rdat; // read data of the last transfer
   logic rerr; // error flag of the last transfer
   logic [15:0] qv; // condition word driven this round
   logic [31:0] seed = 32'h4B9C978C;
   logic [31:0] rates[4] = '{`QSSC_BAUD_19200, `QSSC_BAUD_9600, `QSSC_BAUD_4800, `QSSC_BAUD_2400};
   always #10 pclk = ~pclk;
   always @(negedge pclk) if (beep === 1'b1) beep_n++;
   qssc_top #(.BEEP_CYCLES(BC)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .qcond(qcond), .rx(rx), .cmd_parsed(cmd_parsed), .soft_rst(soft_rst),
      .tx_ready(tx_ready), .tx(tx), .beep(beep), .gpib_addr(gpib_addr),
      .baud_sel(baud_sel), .xoff_hold(xoff_hold), .qsum(qsum)
   );
   qssc_host_model host (
      .pclk(pclk), .presetn(presetn), .tx(tx), .rx(rx), .tx_ready(tx_ready)
   );
   // next value of the bench's random sequence
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // expected read of a questionable word: only used positions show
   function automatic logic [15:0] live_exp(input logic [15:0] q);
      return q & `QSSC_QUSED;
   endfunction
   // one apb transfer: setup, access held until ready, then release
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) bad_count++;
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask
   // send a character and expect it back or not
   task echo_chk(input logic [7:0] c, input logic [31:0] n);
      host.send(c);
      repeat (40) @(negedge pclk);
      `CHK(32'(host.got_q.size()), n, "echo count")
      if (host.got_q.size() > 0) `CHK(host.got_q.pop_front(), c, "echo byte")
      @(posedge pclk);
   endtask
   // verdict and end of run
   task results;
      if (bad_count == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      results();
   end
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      `CHK(gpib_addr, `QSSC_ADDR_RST, "address after reset")
      // live conditions and enable mask with random values
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         qv = seed[15:0] | ((i == 0) ? 16'h0003 : 16'h0000);
         qcond <= qv;
         @(posedge pclk);
         rd(`QSSC_A_QCOND);
         `CHK(rdat[15:0], live_exp(qv), "cond")
         `CHK(rdat[31:16], 16'h0, "cond upper")
         wr(`QSSC_A_QEN, seed >> 16);
         rd(`QSSC_A_QEN);
         `CHK(rdat, {16'h0000, live_exp(seed[31:16])}, "enable")
      end
      qcond <= 16'h0;
      @(posedge pclk);
      rd(`QSSC_A_QEVT);
      // of the driven bits only bit 13 latches, read clears
      qcond <= 16'h604B;
      repeat (2) @(posedge pclk);
      qcond <= 16'h0;
      @(posedge pclk);
      rd(`QSSC_A_QCOND);
      `CHK(rdat, 32'h0, "cond released")
      rd(`QSSC_A_QEVT);
      `CHK(rdat, 32'h2000, "event latch")
      rd(`QSSC_A_QEVT);
      `CHK(rdat, 32'h0, "event clear")
      // summary follows masked events
      wr(`QSSC_A_QEN, 32'h1000);
      qcond <= 16'h1000;
      @(posedge pclk);
      qcond <= 16'h0;
      repeat (3) @(negedge pclk);
      `CHK(qsum, 1'b1, "summary set")
      @(posedge pclk);
      rd(`QSSC_A_STB);
      `CHK(rdat, 32'h1 << `QSSC_B_QSUM, "status byte")
      wr(`QSSC_A_QEN, 32'h2000);
      repeat (2) @(negedge pclk);
      `CHK(qsum, 1'b0, "summary masked")
      @(posedge pclk);
      // bus address, boundary and refused values
      wr(`QSSC_A_ADDR, 32'd17);
      wr(`QSSC_A_ADDR, 32'd31);
      rd(`QSSC_A_ADDR);
      `CHK(rdat, 32'd17, "address kept")
      wr(`QSSC_A_ADDR, 32'd30);
      rd(`QSSC_A_ADDR);
      `CHK(rdat, 32'd30, "address max")
      `CHK(gpib_addr, 5'd30, "address out")
      // every baud rate, then an unsupported one
      for (int i = 0; i < 4; i++) begin
         wr(`QSSC_A_BAUD, rates[i]);
         wr(`QSSC_A_BAUD, 32'd1200);
         rd(`QSSC_A_BAUD);
         `CHK(rdat, rates[i], "baud read")
         `CHK(baud_sel, 2'(i), "baud select")
      end
      // beep length
      beep_n = 0;
      wr(`QSSC_A_BEEP, 32'h1);
      repeat (BC + 10) @(posedge pclk);
      `CHK(beep_n, BC, "beep length")
      rd(8'h20);
      `CHK(rerr, 1'b1, "unmapped")
      // echo on, survives general reset, off only after terminator
      wr(`QSSC_A_CTRL, 32'h1);
      echo_chk(8'h41, 32'd1);
      soft_rst <= 1'b1;
      @(posedge pclk);
      soft_rst <= 1'b0;
      @(posedge pclk);
      rd(`QSSC_A_CTRL);
      `CHK(rdat, 32'h1, "echo kept")
      wr(`QSSC_A_CTRL, 32'h0);
      rd(`QSSC_A_CTRL);
      `CHK(rdat, 32'h0, "echo query")
      echo_chk(8'h42, 32'd1);
      echo_chk(`QSSC_CH_LF, 32'd1);
      echo_chk(8'h43, 32'd0);
      // flow control off and on
      echo_chk(`QSSC_CH_XOFF, 32'd0);
      `CHK(xoff_hold, 1'b0, "no pause")
      wr(`QSSC_A_CTRL, 32'h2);
      rd(`QSSC_A_CTRL);
      `CHK(rdat, 32'h2, "flow query")
      echo_chk(`QSSC_CH_XOFF, 32'd0);
      `CHK(xoff_hold, 1'b1, "paused")
      echo_chk(`QSSC_CH_XON, 32'd0);
      `CHK(xoff_hold, 1'b0, "resumed")
      // prompt after each parsed command, none when off
      for (int i = 0; i < 2; i++) begin
         wr(`QSSC_A_CTRL, (i == 0) ? 32'h4 : 32'h0);
         cmd_parsed <= 1'b1;
         @(posedge pclk);
         cmd_parsed <= 1'b0;
         repeat (40) @(negedge pclk);
         `CHK(32'(host.got_q.size()), 32'(1 - i), "prompt count")
         if (host.got_q.size() > 0)
            `CHK(host.got_q.pop_front(), `QSSC_CH_PROMPT, "prompt")
         @(posedge pclk);
      end
      // prompt held back while paused, released by xon
      wr(`QSSC_A_CTRL, 32'h6);
      host.send(`QSSC_CH_XOFF);
      cmd_parsed <= 1'b1;
      @(posedge pclk);
      cmd_parsed <= 1'b0;
      repeat (40) @(negedge pclk);
      `CHK(32'(host.got_q.size()), 32'd0, "prompt sent while paused")
      @(posedge pclk);
      host.send(`QSSC_CH_XON);
      repeat (40) @(negedge pclk);
      `CHK(32'(host.got_q.size()), 32'd1, "prompt not resumed")
      if (host.got_q.size() > 0)
         `CHK(host.got_q.pop_front(), `QSSC_CH_PROMPT, "resumed char")
      @(posedge pclk);
      results();
   end
endmodule // qssc_top_tb_top
`default_nettype wire
